// file: src/tlsw_pkg.sv
// Package of word offsets, field positions and codes for the loop status words
package tlsw_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 5;
  // Input word offsets relative to the unit's first word
  localparam logic [4:0] OFS_PV_A = 5'h0D;
  localparam logic [4:0] OFS_PV_B = 5'h0E;
  localparam logic [4:0] OFS_SP_A = 5'h0F;
  localparam logic [4:0] OFS_SP_B = 5'h10;
  localparam logic [4:0] OFS_DP_ERR = 5'h11;
  localparam logic [4:0] OFS_STAT_A = 5'h12;
  // Decimal point and error index fields
  localparam int unsigned DP_A_LSB = 12;
  localparam int unsigned DP_B_LSB = 8;
  localparam int unsigned ERRIX_A_LSB = 4;
  localparam int unsigned ERRIX_B_LSB = 0;
  localparam int unsigned NIB_W = 4;
  // Status word bits
  localparam int unsigned ST_SAVE_DONE = 15;
  localparam int unsigned ST_SENSOR_ERR = 14;
  localparam int unsigned ST_RSVD = 13;
  localparam int unsigned ST_FATAL = 12;
  localparam int unsigned ST_STANDBY = 11;
  // Codes
  localparam logic [3:0] BCD_NEG_DIGIT = 4'hF;
  localparam logic [15:0] SENSOR_ERR_WORD = 16'hCCCC;
  localparam logic [13:0] BCD_MAX_POS = 14'h270F;
  localparam logic [13:0] BCD_MAX_NEG = 14'h03E7;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  typedef enum logic [1:0] {
    TLSW_SV_IDLE,
    TLSW_SV_WRITE,
    TLSW_SV_DONE
  } tlsw_save_st_t;
endpackage

// file: src/tlsw_save_if.sv
// Carrier between the word bank and the nonvolatile save sequencer
`timescale 1ns/1ps
interface tlsw_save_if;
  logic save_bit;
  logic nv_done;
  logic nv_start;
  logic complete;
  logic busy;
  modport ctl (input save_bit, input nv_done, output nv_start, output complete, output busy);
  modport bank (output save_bit, output nv_done, input nv_start, input complete, input busy);
endinterface // tlsw_save_if

// file: src/tlsw_val_fmt.sv
// Formatter of a process value or set point into BCD or binary word form
`timescale 1ns/1ps
module tlsw_val_fmt (
  input wire logic [15:0] value,
  input wire logic bcd_mode,
  input wire logic force_err,
  output logic [15:0] word
);
  function automatic logic [15:0] tlsw_bin2bcd(input logic [13:0] v);
    logic [15:0] d;
    d = tlsw_pkg::WORD_ZERO;
    for (int i = 13; i >= 0; i--) begin
      for (int k = 0; k < 4; k++) begin
        if (d[k*4 +: 4] > 4'h4) begin
          d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
        end
      end
      d = {d[14:0], v[i]};
    end
    return d;
  endfunction

  logic neg;
  logic [15:0] mag;
  logic [13:0] lim;
  logic [15:0] digits;

  always_comb begin
    neg = value[15];
    mag = neg ? 16'(-value) : value;
    // Out-of-range magnitudes saturate; four digits, or three behind the sign digit, hold no more
    if (neg) begin
      lim = (mag > 16'(tlsw_pkg::BCD_MAX_NEG)) ? tlsw_pkg::BCD_MAX_NEG : mag[13:0];
    end else begin
      lim = (mag > 16'(tlsw_pkg::BCD_MAX_POS)) ? tlsw_pkg::BCD_MAX_POS : mag[13:0];
    end
    digits = tlsw_bin2bcd(lim);
    if (force_err) begin
      word = tlsw_pkg::SENSOR_ERR_WORD;
    end else if (!bcd_mode) begin
      word = value;
    end else if (neg) begin
      word = {tlsw_pkg::BCD_NEG_DIGIT, digits[11:0]};
    end else begin
      word = digits;
    end
  end
endmodule // tlsw_val_fmt

// file: src/tlsw_save_ctl.sv
// Sequencer for copying operating parameters into nonvolatile storage
`timescale 1ns/1ps
module tlsw_save_ctl (
  input wire logic mclk,
  input wire logic reset,
  tlsw_save_if.ctl sv
);
  tlsw_pkg::tlsw_save_st_t st_r;
  logic bit_d_r;
  logic rise;

  assign rise = sv.save_bit & ~bit_d_r;
  assign sv.complete = (st_r == tlsw_pkg::TLSW_SV_DONE);
  assign sv.busy = (st_r == tlsw_pkg::TLSW_SV_WRITE);

  always_ff @(posedge mclk) begin
    if (reset) begin
      bit_d_r <= 1'b0;
    end else begin
      bit_d_r <= sv.save_bit;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sv.nv_start <= 1'b0;
    end else begin
      sv.nv_start <= rise & (st_r != tlsw_pkg::TLSW_SV_WRITE);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= tlsw_pkg::TLSW_SV_IDLE;
    end else begin
      unique case (st_r)
        tlsw_pkg::TLSW_SV_IDLE: begin
          if (rise) begin
            st_r <= tlsw_pkg::TLSW_SV_WRITE;
          end
        end
        tlsw_pkg::TLSW_SV_WRITE: begin
          if (sv.nv_done) begin
            st_r <= tlsw_pkg::TLSW_SV_DONE;
          end
        end
        tlsw_pkg::TLSW_SV_DONE: begin
          if (rise) begin
            st_r <= tlsw_pkg::TLSW_SV_WRITE;
          end
        end
        // The fourth code of the state word is never entered
        default: begin
          st_r <= tlsw_pkg::TLSW_SV_IDLE;
        end
      endcase
    end
  end
endmodule // tlsw_save_ctl

// file: src/temp_loop_status_words.sv
// Input word bank returned to the host controller for two control loops
`timescale 1ns/1ps
module temp_loop_status_words #(
  parameter int unsigned IO_ADDR_W = tlsw_pkg::ADDR_W
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic io_rd,
  input wire logic [IO_ADDR_W-1:0] io_addr,
  output logic [15:0] io_rd_data,
  output logic io_rd_valid,
  input wire logic host_save_bit,
  input wire logic unit_restart,
  input wire logic bcd_mode,
  input wire logic [15:0] pv_a,
  input wire logic [15:0] pv_b,
  input wire logic [15:0] sp_a,
  input wire logic [15:0] sp_b,
  input wire logic over_range_a,
  input wire logic over_range_b,
  input wire logic sensor_absent_a,
  input wire logic sensor_broken_a,
  input wire logic [3:0] dp_a,
  input wire logic [3:0] dp_b,
  input wire logic [3:0] err_ix_a,
  input wire logic [3:0] err_ix_b,
  input wire logic cjc_fault,
  input wire logic host_watchdog_err,
  output logic nv_write_start,
  input wire logic nv_write_done,
  output logic save_busy,
  output logic standby
);
  // Refused at elaboration: narrower addresses cannot reach all the mapped words
  if (IO_ADDR_W < tlsw_pkg::ADDR_W) begin : g_addr_w_chk
    $error("IO_ADDR_W too narrow for the word offsets");
  end

  tlsw_save_if sv ();

  logic [15:0] pv_a_w;
  logic [15:0] pv_b_w;
  logic [15:0] sp_a_w;
  logic [15:0] sp_b_w;
  logic [15:0] pv_a_r;
  logic [15:0] pv_b_r;
  logic [15:0] sp_a_r;
  logic [15:0] sp_b_r;
  logic [15:0] dp_err_r;
  logic [15:0] stat_a_r;
  logic [15:0] stat_nxt;
  logic [15:0] rd_nxt;
  logic sensor_err_a;
  logic standby_r;

  // Save path through the sequencer
  assign sv.save_bit = host_save_bit;
  assign sv.nv_done = nv_write_done;

  tlsw_save_ctl u_save (
    .mclk(mclk),
    .reset(reset),
    .sv(sv)
  );

  tlsw_val_fmt u_pv_a (
    .value(pv_a),
    .bcd_mode(bcd_mode),
    .force_err(over_range_a),
    .word(pv_a_w)
  );

  tlsw_val_fmt u_pv_b (
    .value(pv_b),
    .bcd_mode(bcd_mode),
    .force_err(over_range_b),
    .word(pv_b_w)
  );

  tlsw_val_fmt u_sp_a (
    .value(sp_a),
    .bcd_mode(bcd_mode),
    .force_err(1'b0),
    .word(sp_a_w)
  );

  tlsw_val_fmt u_sp_b (
    .value(sp_b),
    .bcd_mode(bcd_mode),
    .force_err(1'b0),
    .word(sp_b_w)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      pv_a_r <= tlsw_pkg::WORD_ZERO;
      pv_b_r <= tlsw_pkg::WORD_ZERO;
    end else begin
      pv_a_r <= pv_a_w;
      pv_b_r <= pv_b_w;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sp_a_r <= tlsw_pkg::WORD_ZERO;
      sp_b_r <= tlsw_pkg::WORD_ZERO;
    end else begin
      sp_a_r <= sp_a_w;
      sp_b_r <= sp_b_w;
    end
  end

  // Decimal point and error index word
  always_ff @(posedge mclk) begin
    if (reset) begin
      dp_err_r <= tlsw_pkg::WORD_ZERO;
    end else begin
      dp_err_r[tlsw_pkg::DP_A_LSB +: tlsw_pkg::NIB_W] <= dp_a;
      dp_err_r[tlsw_pkg::DP_B_LSB +: tlsw_pkg::NIB_W] <= dp_b;
      dp_err_r[tlsw_pkg::ERRIX_A_LSB +: tlsw_pkg::NIB_W] <= err_ix_a;
      dp_err_r[tlsw_pkg::ERRIX_B_LSB +: tlsw_pkg::NIB_W] <= err_ix_b;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      standby_r <= 1'b1;
    end else if (unit_restart) begin
      // A restart in the same cycle as a read still leaves the unit waiting
      standby_r <= 1'b1;
    end else if (io_rd) begin
      standby_r <= 1'b0;
    end
  end

  assign sensor_err_a = sensor_absent_a | sensor_broken_a | over_range_a;

  always_comb begin
    stat_nxt = tlsw_pkg::WORD_ZERO;
    stat_nxt[tlsw_pkg::ST_SAVE_DONE] = sv.complete;
    stat_nxt[tlsw_pkg::ST_SENSOR_ERR] = sensor_err_a;
    stat_nxt[tlsw_pkg::ST_RSVD] = 1'b0;
    stat_nxt[tlsw_pkg::ST_FATAL] = cjc_fault | host_watchdog_err;
    stat_nxt[tlsw_pkg::ST_STANDBY] = standby_r;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stat_a_r <= tlsw_pkg::WORD_ZERO;
    end else begin
      stat_a_r <= stat_nxt;
    end
  end

  // Read decode; unmapped words read zero
  always_comb begin
    unique case (io_addr[tlsw_pkg::ADDR_W-1:0])
      tlsw_pkg::OFS_PV_A: rd_nxt = pv_a_r;
      tlsw_pkg::OFS_PV_B: rd_nxt = pv_b_r;
      tlsw_pkg::OFS_SP_A: rd_nxt = sp_a_r;
      tlsw_pkg::OFS_SP_B: rd_nxt = sp_b_r;
      tlsw_pkg::OFS_DP_ERR: rd_nxt = dp_err_r;
      tlsw_pkg::OFS_STAT_A: rd_nxt = stat_a_r;
      default: rd_nxt = tlsw_pkg::WORD_ZERO;
    endcase
    if (IO_ADDR_W > tlsw_pkg::ADDR_W) begin
      if ((io_addr >> tlsw_pkg::ADDR_W) != '0) begin
        rd_nxt = tlsw_pkg::WORD_ZERO;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      io_rd_data <= tlsw_pkg::WORD_ZERO;
      io_rd_valid <= 1'b0;
    end else begin
      io_rd_valid <= io_rd;
      if (io_rd) begin
        io_rd_data <= rd_nxt;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      nv_write_start <= 1'b0;
      save_busy <= 1'b0;
      standby <= 1'b1;
    end else begin
      nv_write_start <= sv.nv_start;
      save_busy <= sv.busy;
      standby <= standby_r;
    end
  end
endmodule // temp_loop_status_words

// file: tb/tlsw_props.sv
// Checker of read timing, status bits and save handshake
`timescale 1ns/1ps
module tlsw_props #(
  parameter int unsigned IO_ADDR_W = 5
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic io_rd,
  input wire logic [IO_ADDR_W-1:0] io_addr,
  input wire logic [15:0] io_rd_data,
  input wire logic io_rd_valid,
  input wire logic host_save_bit,
  input wire logic unit_restart,
  input wire logic over_range_a,
  input wire logic sensor_absent_a,
  input wire logic sensor_broken_a,
  input wire logic cjc_fault,
  input wire logic host_watchdog_err,
  input wire logic nv_write_start,
  input wire logic nv_write_done,
  input wire logic save_busy,
  input wire logic standby
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic st_rd;
  logic sens;
  logic fatal;
  assign st_rd = io_rd && io_addr == tlsw_pkg::OFS_STAT_A;
  assign sens = sensor_absent_a || sensor_broken_a || over_range_a;
  assign fatal = cjc_fault || host_watchdog_err;
  property p_rd_valid; io_rd |=> io_rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer missing");
  property p_unmapped; io_rd && (io_addr < 5'h0D || io_addr > 5'h12) |=> io_rd_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rsvd; st_rd |=> !io_rd_data[13]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_sens; st_rd && $stable(sens) && !$past(reset) |=> io_rd_data[14] == $past(sens);
  endproperty
  a_sens: assert property (p_sens) else $error("sensor error bit wrong");
  property p_fatal; st_rd && $stable(fatal) && !$past(reset) |=> io_rd_data[12] == $past(fatal);
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal error bit wrong");
  property p_stby_clr; io_rd && !unit_restart |-> ##2 !standby; endproperty
  a_stby_clr: assert property (p_stby_clr) else $error("standby not cleared");
  property p_stby_set; unit_restart |-> ##2 standby; endproperty
  a_stby_set: assert property (p_stby_set) else $error("standby not set");
  property p_start; $rose(host_save_bit) && !save_busy && !nv_write_done |-> ##[1:2] nv_write_start;
  endproperty
  a_start: assert property (p_start) else $error("save start missing");
  property p_start_busy; nv_write_start |-> save_busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
endmodule // tlsw_props
bind temp_loop_status_words tlsw_props #(.IO_ADDR_W(IO_ADDR_W)) u_tlsw_props (.mclk, .reset,
  .io_rd, .io_addr, .io_rd_data, .io_rd_valid, .host_save_bit, .unit_restart, .over_range_a,
  .sensor_absent_a, .sensor_broken_a, .cjc_fault, .host_watchdog_err, .nv_write_start,
  .nv_write_done, .save_busy, .standby);

// file: tb/tlsw_nv_model.sv
// Nonvolatile writer model answering each start after a set delay
`timescale 1ns/1ps
module tlsw_nv_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic [3:0] lat,
  output logic done
);
  logic [4:0] cnt_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= 5'h00;
    end else if (start) begin
      cnt_r <= {1'b0, lat} + 5'h01;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end
  // Single-cycle pulse, the shortest form the design must accept
  assign done = cnt_r == 5'h01;
endmodule // tlsw_nv_model

// file: tb/temp_loop_status_words_tb.sv
// Self-checking bench for the loop status word bank
`timescale 1ns/1ps
module temp_loop_status_words_tb;
  logic mclk, reset, io_rd, io_rd_valid, host_save_bit, unit_restart, bcd_mode;
  logic over_range_a, over_range_b, sensor_absent_a, sensor_broken_a, cjc_fault;
  logic host_watchdog_err, nv_write_start, nv_write_done, save_busy, standby;
  logic [4:0] io_addr;
  logic [15:0] io_rd_data, pv_a, pv_b, sp_a, sp_b, rd;
  logic [3:0] dp_a, dp_b, err_ix_a, err_ix_b, lat;
  logic [15:0] cor [4] = '{16'h270F, 16'hFC19, 16'hD8F0, 16'h2710};
  int err_total, n_compared, seed;
  temp_loop_status_words u_temp_loop_status_words (.mclk, .reset, .io_rd, .io_addr,
    .io_rd_data, .io_rd_valid, .host_save_bit, .unit_restart, .bcd_mode, .pv_a, .pv_b,
    .sp_a, .sp_b, .over_range_a, .over_range_b, .sensor_absent_a, .sensor_broken_a, .dp_a,
    .dp_b, .err_ix_a, .err_ix_b, .cjc_fault, .host_watchdog_err, .nv_write_start,
    .nv_write_done, .save_busy, .standby);
  tlsw_nv_model u_tlsw_nv_model (.mclk, .reset, .start(nv_write_start), .lat,
    .done(nv_write_done));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdw(logic [4:0] a);
    io_rd = 1'b1;
    io_addr = a;
    @(negedge mclk);
    rd = io_rd_data;
    chk("read valid", 16'h0001, {15'h0000, io_rd_valid});
    io_rd = 1'b0;
    // Let an edge pass so a following read never re-raises the strobe at once
    @(negedge mclk);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    for (int k = 0; k < 60 && s !== v; k++) @(negedge mclk);
    chk("wait", {15'h0000, v}, {15'h0000, s});
    if (s !== v) print_verdict();
  endtask
  // BCD saturates at 9999 up and 999 down, top digit F when negative
  function automatic logic [15:0] fmt(logic [15:0] v, logic b, logic e);
    logic [15:0] m, w, lim;
    lim = v[15] ? 16'h03E7 : 16'h270F;
    m = v[15] ? -v : v;
    if (m > lim) m = lim;
    for (int k = 0; k < 4; k++) begin
      w[4*k +: 4] = 4'(m % 16'h000A);
      m = m / 16'h000A;
    end
    if (v[15]) w[15:12] = 4'hF;
    return e ? 16'hCCCC : (b ? w : v);
  endfunction
  initial begin
    seed = 32'hC81F726F;
    err_total = 0;
    n_compared = 0;
    reset = 1'b1;
    {io_rd, host_save_bit, unit_restart, bcd_mode, over_range_a, over_range_b} = '0;
    {sensor_absent_a, sensor_broken_a, cjc_fault, host_watchdog_err} = '0;
    {pv_a, pv_b, sp_a, sp_b, dp_a, dp_b, err_ix_a, err_ix_b} = '0;
    io_addr = 5'h00;
    lat = 4'h0;
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    repeat (3) @(negedge mclk);
    rdw(tlsw_pkg::OFS_STAT_A);
    chk("status after reset", 16'h0800, rd);
    chk("standby after read", 16'h0000, {15'h0000, standby});
    unit_restart = 1'b1;
    @(negedge mclk);
    unit_restart = 1'b0;
    // Standby pin trails the internal flag by one edge
    @(negedge mclk);
    chk("standby after restart", 16'h0001, {15'h0000, standby});
    repeat (2) @(negedge mclk);
    rdw(tlsw_pkg::OFS_STAT_A);
    chk("standby bit", 16'h0800, rd & 16'h0800);
    $display("test standby done");
    for (int n = 0; n < 24; n++) begin
      pv_a = n < 4 ? cor[n] : 16'($random(seed));
      sp_a = n < 4 ? cor[3-n] : 16'($random(seed));
      pv_b = 16'($random(seed));
      sp_b = 16'($random(seed));
      {bcd_mode, over_range_a, over_range_b, dp_a, dp_b, err_ix_a, err_ix_b} = 19'($random(seed));
      if (n < 4) bcd_mode = 1'b1;
      repeat (2) @(negedge mclk);
      rdw(tlsw_pkg::OFS_PV_A);
      chk("pv a", fmt(pv_a, bcd_mode, over_range_a), rd);
      rdw(tlsw_pkg::OFS_PV_B);
      chk("pv b", fmt(pv_b, bcd_mode, over_range_b), rd);
      rdw(tlsw_pkg::OFS_SP_A);
      chk("sp a", fmt(sp_a, bcd_mode, 1'b0), rd);
      rdw(tlsw_pkg::OFS_SP_B);
      chk("sp b", fmt(sp_b, bcd_mode, 1'b0), rd);
      rdw(tlsw_pkg::OFS_DP_ERR);
      chk("dp and error index", {dp_a, dp_b, err_ix_a, err_ix_b}, rd);
    end
    foreach (cor[n]) begin
      rdw(5'h13 + 5'(n * 4));
      chk("unmapped", 16'h0000, rd);
    end
    $display("test words done");
    for (int n = 0; n < 5; n++) begin
      {sensor_absent_a, sensor_broken_a, over_range_a, cjc_fault, host_watchdog_err} = 5'h10 >> n;
      repeat (3) @(negedge mclk);
      rdw(tlsw_pkg::OFS_STAT_A);
      chk("status flags", n < 3 ? 16'h4000 : 16'h1000, rd & 16'hF800);
    end
    host_watchdog_err = 1'b0;
    $display("test flags done");
    for (int n = 0; n < 2; n++) begin
      lat = n ? 4'hF : 4'h0;
      host_save_bit = 1'b1;
      wait_for(nv_write_start, 1'b1);
      rdw(tlsw_pkg::OFS_STAT_A);
      chk("save done cleared", 16'h0000, rd & 16'h8000);
      host_save_bit = 1'b0;
      wait_for(save_busy, 1'b0);
      repeat (2) @(negedge mclk);
      rdw(tlsw_pkg::OFS_STAT_A);
      chk("save done set", 16'h8000, rd & 16'h8000);
    end
    $display("test save done");
    // Mid-run reset must drop the completion flag and restore standby
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    rdw(tlsw_pkg::OFS_STAT_A);
    chk("status after second reset", 16'h0800, rd);
    $display("test reset done");
    print_verdict();
  end
endmodule // temp_loop_status_words_tb
